// File: rtl/uart_ctl_pkg.sv
`default_nettype none
package uart_ctl_pkg;
   // register offsets on the plain register port
   localparam logic [2:0] OFS_RX_TX = 3'h0;
   localparam logic [2:0] OFS_INT_ENABLE = 3'h1;
   localparam logic [2:0] OFS_IDENT_FIFO = 3'h2;
   localparam logic [2:0] OFS_MODEM_CTL = 3'h4;
   localparam logic [2:0] OFS_LINE_STATUS = 3'h5;
   localparam logic [2:0] OFS_MODEM_STATUS = 3'h6;
   // fifo control fields
   localparam int FCR_ENABLE = 0;
   localparam int FCR_RX_RESET = 1;
   localparam int FCR_TX_RESET = 2;
   localparam int FCR_DMA = 3;
   localparam int FCR_LVL_LO = 6;
   localparam logic [4:0] LVL_CODE0 = 5'h01;
   localparam logic [4:0] LVL_CODE1 = 5'h04;
   localparam logic [4:0] LVL_CODE2 = 5'h08;
   localparam logic [4:0] LVL_CODE3 = 5'h0E;
   // modem control fields
   localparam int MCR_LOOP = 4;
   // interrupt enable fields
   localparam int IER_RDR = 0;
   localparam int IER_THR = 1;
   localparam int IER_LSR = 2;
   localparam int IER_MSR = 3;
   // interrupt identification codes, bits 3:0
   localparam logic [3:0] ID_NONE = 4'h1;
   localparam logic [3:0] ID_LINE = 4'h6;
   localparam logic [3:0] ID_DATA = 4'h4;
   localparam logic [3:0] ID_TIMEOUT = 4'hC;
   localparam logic [3:0] ID_TX_EMPTY = 4'h2;
   localparam logic [3:0] ID_MODEM = 4'h0;
   localparam logic [7:0] IDENT_RESET = 8'h01;
   localparam logic [7:0] BYTE_ZERO = 8'h00;
   // character-time timeout: four characters
   localparam int TIMEOUT_CHARS = 4;

   typedef struct packed {
      logic dcd_n;
      logic ri_n;
      logic dsr_n;
      logic cts_n;
   } modem_pins_t;

   typedef struct packed {
      logic [2:0] addr;
      logic [7:0] wdata;
      logic wr;
      logic rd;
   } reg_req_t;

   typedef struct packed {
      logic overrun;
      logic parity;
      logic stop_missing;
      logic brk;
   } line_err_t;
endpackage : uart_ctl_pkg
`default_nettype wire

// File: rtl/uart_modem_fifo_intr.sv
// Our own choices: strobed register access and the register offsets.
`default_nettype none
module uart_modem_fifo_intr
   import uart_ctl_pkg::*;
#(
   parameter int CHAR_CYCLES = 10,
   parameter int COUNT_W = 5
)(
   input wire logic clk,
   input wire logic nrst,
   input wire uart_ctl_pkg::reg_req_t req,
   output logic [7:0] rdata,
   input wire uart_ctl_pkg::modem_pins_t pins,
   input wire logic [7:0] rx_data,
   input wire logic [COUNT_W-1:0] rx_count,
   input wire uart_ctl_pkg::line_err_t line_err,
   input wire logic tx_empty,
   input wire logic rx_access,
   output logic tx_fifo_reset,
   output logic rx_fifo_reset,
   output logic fifo_mode,
   output logic dma_mode1,
   output logic [7:0] tx_write_data,
   output logic tx_write,
   output logic rx_read
);
   import uart_ctl_pkg::*;

   localparam int TIMEOUT_CYCLES = TIMEOUT_CHARS * CHAR_CYCLES;
   localparam int TW = $clog2(TIMEOUT_CYCLES + 1);

   function automatic logic [COUNT_W-1:0] level_of(input logic [1:0] code);
      case (code)
         2'b00: level_of = COUNT_W'(LVL_CODE0);
         2'b01: level_of = COUNT_W'(LVL_CODE1);
         2'b10: level_of = COUNT_W'(LVL_CODE2);
         default: level_of = COUNT_W'(LVL_CODE3);
      endcase
   endfunction : level_of

   function automatic logic is_rd(input reg_req_t r, input logic [2:0] ofs);
      is_rd = r.rd && (r.addr == ofs);
   endfunction : is_rd

   function automatic logic is_wr(input reg_req_t r, input logic [2:0] ofs);
      is_wr = r.wr && (r.addr == ofs);
   endfunction : is_wr

   logic [3:0] pin_s1_q;
   logic [3:0] pin_s2_q;
   logic [3:0] prev_q;
   logic [3:0] live;
   logic [3:0] chg_q;
   logic [7:0] fcr_q;
   logic [3:0] ier_q;
   logic [4:0] mcr_q;
   logic thr_flag_q;
   logic tx_empty_q;
   logic [TW-1:0] idle_q;
   logic timeout_q;
   logic [3:0] ident_code;
   logic line_p;
   logic data_p;
   logic tx_p;
   logic modem_p;

   // two-stage synchroniser for the modem pins
   always_ff @(posedge clk or negedge nrst)
   begin
      if (!nrst)
      begin
         pin_s1_q <= 4'hF;
         pin_s2_q <= 4'hF;
      end
      else
      begin
         pin_s1_q <= pins;
         pin_s2_q <= pin_s1_q;
      end
   end

   // live status order: dcd, ri, dsr, cts (active high)
   always_comb
   begin
      if (mcr_q[MCR_LOOP])
         live = {mcr_q[3], mcr_q[2], mcr_q[0], mcr_q[1]};
      else
         live = ~pin_s2_q;
   end

   always_ff @(posedge clk or negedge nrst)
   begin
      if (!nrst)
         prev_q <= 4'h0;
      else
         prev_q <= live;
   end

   // change flags: a change in the read cycle survives the clear
   always_ff @(posedge clk or negedge nrst)
   begin
      if (!nrst)
         chg_q <= 4'h0;
      else
      begin
         chg_q[3] <= (chg_q[3] && !is_rd(req, OFS_MODEM_STATUS))
            || (live[3] != prev_q[3]);
         chg_q[2] <= (chg_q[2] && !is_rd(req, OFS_MODEM_STATUS))
            || (prev_q[2] && !live[2]);
         chg_q[1] <= (chg_q[1] && !is_rd(req, OFS_MODEM_STATUS))
            || (live[1] != prev_q[1]);
         chg_q[0] <= (chg_q[0] && !is_rd(req, OFS_MODEM_STATUS))
            || (live[0] != prev_q[0]);
      end
   end

   // fifo control; reset bits self-clear after one cycle
   always_ff @(posedge clk or negedge nrst)
   begin
      if (!nrst)
         fcr_q <= BYTE_ZERO;
      else if (is_wr(req, OFS_IDENT_FIFO))
         fcr_q <= req.wdata;
      else
      begin
         fcr_q[FCR_TX_RESET] <= 1'b0;
         fcr_q[FCR_RX_RESET] <= 1'b0;
      end
   end

   assign tx_fifo_reset = fcr_q[FCR_TX_RESET];
   assign rx_fifo_reset = fcr_q[FCR_RX_RESET];
   assign fifo_mode = fcr_q[FCR_ENABLE];
   assign dma_mode1 = fcr_q[FCR_DMA] && fcr_q[FCR_ENABLE];

   always_ff @(posedge clk or negedge nrst)
   begin
      if (!nrst)
      begin
         ier_q <= 4'h0;
         mcr_q <= 5'h00;
      end
      else
      begin
         if (is_wr(req, OFS_INT_ENABLE))
            ier_q <= req.wdata[3:0];
         if (is_wr(req, OFS_MODEM_CTL))
            mcr_q <= req.wdata[4:0];
      end
   end

   assign tx_write = is_wr(req, OFS_RX_TX);
   assign tx_write_data = req.wdata;
   assign rx_read = is_rd(req, OFS_RX_TX);

   // transmit-empty source: set on rising empty, cleared by write or by ident read reporting ID_TX_EMPTY
   always_ff @(posedge clk or negedge nrst)
   begin
      if (!nrst)
      begin
         tx_empty_q <= 1'b0;
         thr_flag_q <= 1'b0;
      end
      else
      begin
         tx_empty_q <= tx_empty;
         if (tx_empty && !tx_empty_q)
            thr_flag_q <= 1'b1;
         else if (tx_write
            || (is_rd(req, OFS_IDENT_FIFO) && ident_code == ID_TX_EMPTY))
            thr_flag_q <= 1'b0;
      end
   end

   // receive timeout: idle time counted from last fifo access
   always_ff @(posedge clk or negedge nrst)
   begin
      if (!nrst)
      begin
         idle_q <= '0;
         timeout_q <= 1'b0;
      end
      else if (rx_access || rx_read || rx_count == '0 || !fcr_q[FCR_ENABLE])
      begin
         idle_q <= '0;
         timeout_q <= 1'b0;
      end
      else if (idle_q == TW'(TIMEOUT_CYCLES))
         timeout_q <= 1'b1;
      else
         idle_q <= idle_q + TW'(1);
   end

   always_comb
   begin
      line_p = ier_q[IER_LSR] && (|line_err);
      if (fcr_q[FCR_ENABLE])
         data_p = ier_q[IER_RDR]
            && (rx_count >= level_of(fcr_q[7:FCR_LVL_LO]));
      else
         data_p = ier_q[IER_RDR] && (rx_count != '0);
      tx_p = ier_q[IER_THR] && thr_flag_q;
      modem_p = ier_q[IER_MSR] && (|chg_q);
   end

   // fixed priority encoder
   always_comb
   begin
      if (line_p)
         ident_code = ID_LINE;
      else if (data_p)
         ident_code = ID_DATA;
      else if (ier_q[IER_RDR] && timeout_q && fcr_q[FCR_ENABLE])
         ident_code = ID_TIMEOUT;
      else if (tx_p)
         ident_code = ID_TX_EMPTY;
      else if (modem_p)
         ident_code = ID_MODEM;
      else
         ident_code = ID_NONE;
   end

   always_ff @(posedge clk or negedge nrst)
   begin
      if (!nrst)
         rdata <= BYTE_ZERO;
      else if (req.rd)
      begin
         case (req.addr)
            OFS_RX_TX: rdata <= rx_data;
            OFS_INT_ENABLE: rdata <= {4'h0, ier_q};
            OFS_IDENT_FIFO: rdata <= {{2{fcr_q[FCR_ENABLE]}}, 2'b00, ident_code};
            OFS_MODEM_CTL: rdata <= {3'h0, mcr_q};
            OFS_LINE_STATUS: rdata <= {4'h0, line_err};
            OFS_MODEM_STATUS: rdata <= {live, chg_q};
            default: rdata <= BYTE_ZERO;
         endcase
      end
      else
         rdata <= BYTE_ZERO;
   end
endmodule : uart_modem_fifo_intr
`default_nettype wire

// File: test/modem_peer.sv
`default_nettype none
module modem_peer
(
   input wire logic clk,
   input wire uart_ctl_pkg::modem_pins_t want,
   output var uart_ctl_pkg::modem_pins_t pins
);
   timeunit 1ns;
   timeprecision 1ps;
   import uart_ctl_pkg::*;
   // handshake lines follow the requested levels one edge later
   always_ff @(posedge clk)
   begin
      pins <= want;
   end
endmodule : modem_peer
`default_nettype wire

// File: test/tb_uart_modem_fifo_intr.sv
`default_nettype none
module tb_uart_modem_fifo_intr;
   timeunit 1ns;
   timeprecision 1ps;
   import uart_ctl_pkg::*;
   typedef struct packed {
      logic [7:0] f;
      logic [4:0] c;
      logic [7:0] id;
      logic [1:0] md;
   } row_t;
   row_t rows[12] = '{'{8'h01, 5'h00, 8'hC1, 2'h1}, '{8'h01, 5'h01, 8'hC4, 2'h1},
      '{8'h41, 5'h03, 8'hC1, 2'h1}, '{8'h41, 5'h04, 8'hC4, 2'h1}, '{8'h81, 5'h07, 8'hC1, 2'h1},
      '{8'h81, 5'h08, 8'hC4, 2'h1}, '{8'hC1, 5'h0D, 8'hC1, 2'h1}, '{8'hC1, 5'h0E, 8'hC4, 2'h1},
      '{8'h07, 5'h00, 8'hC1, 2'h1}, '{8'h09, 5'h00, 8'hC1, 2'h3}, '{8'h08, 5'h00, 8'h01, 2'h0},
      '{8'h00, 5'h01, 8'h04, 2'h0}};
   logic [3:0] steps[5] = '{4'hE, 4'hC, 4'h8, 4'h0, 4'hF};
   logic clk = 1'b0;
   logic nrst = 1'b0;
   reg_req_t req = '0;
   modem_pins_t pins;
   modem_pins_t want = 4'hF;
   logic [7:0] rx_data = 8'h5A;
   logic [4:0] rx_count = 5'h00;
   line_err_t line_err = '0;
   logic tx_empty = 1'b0;
   logic rx_access = 1'b0;
   logic [7:0] rdata, tx_write_data, v, e;
   logic tx_fifo_reset, rx_fifo_reset, fifo_mode, dma_mode1, tx_write, rx_read;
   logic [3:0] o;
   int n_errors = 0;
   int checks_done = 0;
   always #10 clk = ~clk;
   modem_peer peer (.clk, .want, .pins);
   uart_modem_fifo_intr #(.CHAR_CYCLES(4)) DUT (.clk, .nrst, .req, .rdata, .pins, .rx_data,
      .rx_count, .line_err, .tx_empty, .rx_access, .tx_fifo_reset, .rx_fifo_reset, .fifo_mode,
      .dma_mode1, .tx_write_data, .tx_write, .rx_read);
   task automatic chk(input logic [7:0] got, input logic [7:0] exp);
      checks_done++;
      if (got !== exp)
      begin
         n_errors++;
         $display("unexpected at %0t got %h expected %h", $time, got, exp);
      end
   endtask : chk
   task automatic wr(input logic [2:0] a, input logic [7:0] d);
      @(posedge clk);
      req <= '{a, d, 1'b1, 1'b0};
      @(posedge clk);
      req <= '0;
   endtask : wr
   task automatic rd(input logic [2:0] a);
      @(posedge clk);
      req <= '{a, 8'h00, 1'b0, 1'b1};
      @(posedge clk);
      req <= '0;
      @(negedge clk);
      v = rdata;
   endtask : rd
   task automatic acc(input logic [4:0] c);
      @(posedge clk);
      rx_count <= c;
      rx_access <= 1'b1;
      @(posedge clk);
      rx_access <= 1'b0;
      repeat (2) @(posedge clk);
   endtask : acc
   task automatic summarize;
      $display("checks %0d errors %0d", checks_done, n_errors);
      if (n_errors == 0 && checks_done > 0)
         $display("Regression OK");
      else
         $display("Regression broken");
      $finish;
   endtask : summarize
   initial
   begin
      repeat (20000) @(posedge clk);
      n_errors++;
      summarize();
   end
   initial
   begin
      repeat (5) @(posedge clk);
      nrst <= 1'b1;
      rd(OFS_IDENT_FIFO);
      chk(v, IDENT_RESET);
      rd(3'h7);
      chk(v, BYTE_ZERO);
      wr(OFS_INT_ENABLE, 8'h01);
      foreach (rows[i])
      begin
         wr(OFS_IDENT_FIFO, rows[i].f);
         @(negedge clk);
         chk({6'h00, dma_mode1, fifo_mode}, {6'h00, rows[i].md});
         acc(rows[i].c);
         rd(OFS_IDENT_FIFO);
         chk(v, rows[i].id);
      end
      wr(OFS_IDENT_FIFO, 8'h41);
      acc(5'h02);
      repeat (24) @(posedge clk);
      rd(OFS_IDENT_FIFO);
      chk(v, 8'hCC);
      rd(OFS_RX_TX);
      chk(v, 8'h5A);
      acc(5'h02);
      rd(OFS_IDENT_FIFO);
      chk(v, 8'hC1);
      wr(OFS_INT_ENABLE, 8'h07);
      line_err <= '{1'b1, 1'b0, 1'b0, 1'b0};
      acc(5'h04);
      rd(OFS_IDENT_FIFO);
      chk(v, 8'hC6);
      rd(OFS_LINE_STATUS);
      chk(v, 8'h08);
      line_err <= '0;
      rd(OFS_IDENT_FIFO);
      chk(v, 8'hC4);
      rx_count <= 5'h00;
      tx_empty <= 1'b1;
      rd(OFS_IDENT_FIFO);
      chk(v, 8'hC2);
      rd(OFS_IDENT_FIFO);
      chk(v, 8'hC1);
      tx_empty <= 1'b0;
      @(posedge clk);
      tx_empty <= 1'b1;
      rd(OFS_IDENT_FIFO);
      chk(v, 8'hC2);
      wr(OFS_RX_TX, 8'h3C);
      rd(OFS_IDENT_FIFO);
      chk(v, 8'hC1);
      wr(OFS_INT_ENABLE, 8'h08);
      line_err <= '{1'b0, 1'b1, 1'b0, 1'b0};
      wr(OFS_IDENT_FIFO, 8'h00);
      rd(OFS_IDENT_FIFO);
      chk(v, IDENT_RESET);
      line_err <= '0;
      rd(OFS_MODEM_STATUS);
      o = 4'hF;
      foreach (steps[i])
      begin
         @(posedge clk);
         want <= steps[i];
         repeat (5) @(posedge clk);
         e = {~steps[i], ((o ^ steps[i]) & 4'hB) | (steps[i] & ~o & 4'h4)};
         rd(OFS_IDENT_FIFO);
         chk(v, (e[3:0] != 4'h0) ? BYTE_ZERO : IDENT_RESET);
         rd(OFS_MODEM_STATUS);
         chk(v, e);
         rd(OFS_MODEM_STATUS);
         chk(v, {e[7:4], 4'h0});
         o = steps[i];
      end
      wr(OFS_MODEM_CTL, 8'h15);
      rd(OFS_MODEM_STATUS);
      rd(OFS_MODEM_STATUS);
      chk(v, 8'h60);
      summarize();
   end
endmodule : tb_uart_modem_fifo_intr
bind uart_modem_fifo_intr mfi_checker u_chk (.clk, .nrst, .req, .rdata, .tx_fifo_reset,
   .rx_fifo_reset, .fifo_mode, .dma_mode1, .tx_write_data, .tx_write, .rx_read);
`default_nettype wire

// File: test/uart_modem_fifo_intr_assertions.sv
`default_nettype none
module mfi_checker
(
   input wire logic clk,
   input wire logic nrst,
   input wire uart_ctl_pkg::reg_req_t req,
   input wire logic [7:0] rdata,
   input wire logic tx_fifo_reset,
   input wire logic rx_fifo_reset,
   input wire logic fifo_mode,
   input wire logic dma_mode1,
   input wire logic [7:0] tx_write_data,
   input wire logic tx_write,
   input wire logic rx_read
);
   timeunit 1ns;
   timeprecision 1ps;
   import uart_ctl_pkg::*;
   default clocking cb @(posedge clk);
   endclocking
   default disable iff (!nrst);
   sequence s_fcr;
      req.wr && req.addr == OFS_IDENT_FIFO;
   endsequence
   sequence s_id;
      req.rd && req.addr == OFS_IDENT_FIFO;
   endsequence
   property p_tx_rst;
      s_fcr ##0 req.wdata[FCR_TX_RESET] |=> tx_fifo_reset ##1 !tx_fifo_reset;
   endproperty
   a_tx_rst: assert property (p_tx_rst) else $error("tx reset pulse wrong");
   property p_rx_rst;
      s_fcr ##0 req.wdata[FCR_RX_RESET] |=> rx_fifo_reset ##1 !rx_fifo_reset;
   endproperty
   a_rx_rst: assert property (p_rx_rst) else $error("rx reset pulse wrong");
   property p_fifo;
      s_fcr |=> fifo_mode == $past(req.wdata[FCR_ENABLE]);
   endproperty
   a_fifo: assert property (p_fifo) else $error("fifo mode wrong");
   property p_dma;
      s_fcr |=> dma_mode1 == ($past(req.wdata[FCR_DMA]) && $past(req.wdata[FCR_ENABLE]));
   endproperty
   a_dma: assert property (p_dma) else $error("dma mode wrong");
   property p_id_hi;
      s_id |=> rdata[7:4] == {{2{$past(fifo_mode)}}, 2'b00};
   endproperty
   a_id_hi: assert property (p_id_hi) else $error("ident high bits wrong");
   property p_id_b3;
      s_id ##0 !fifo_mode |=> !rdata[3];
   endproperty
   a_id_b3: assert property (p_id_b3) else $error("ident bit 3 set");
   property p_id_idle;
      s_id |=> !rdata[0] || rdata[3:0] == ID_NONE;
   endproperty
   a_id_idle: assert property (p_id_idle) else $error("idle ident wrong");
   property p_strobe;
      tx_write == (req.wr && req.addr == OFS_RX_TX) && rx_read == (req.rd && req.addr == OFS_RX_TX)
         && (!tx_write || tx_write_data == req.wdata);
   endproperty
   a_strobe: assert property (p_strobe) else $error("buffer strobe wrong");
endmodule : mfi_checker
`default_nettype wire
